// ---- logic/uem_core.sv ----
// Endpoint mode and count registers of a full-speed serial interface
// engine, with Wishbone slave access and per-transaction updates.
// Assumes the engine delivers token, data-end and handshake strobes
// as one-cycle pulses synchronous to sys_clk.
//
// Function
// (R01) Mode 0000 gives no answer at all to SETUP, IN or OUT.
// (R02) Mode 0001 accepts SETUP, NAKs IN/OUT; SETUP forces 0001 on control.
// (R03) Control modes accept SETUP; isochronous modes ignore SETUP.
// (R04) 1000 NAKs OUT; 1001 ACKs or stalls OUT, becomes 1000 after ACK.
// (R05) 1010/1011 send zero-length IN; OUT NAK or ACK; 1011 becomes 1010.
// (R06) 1100 NAKs IN; 1101 sends counted IN or stalls; becomes 1100.
// (R07) 1110/1111 check OUT; IN NAK or counted; 1111 becomes 1110.
// (R08) Stall bit stalls OUT in ACK-IN and IN in ACK-OUT.
// (R09) Firmware keeps stall bit low in all other modes.
// (R10) ACK flag is set when a transaction ends with ACK.
// (R11) Firmware writes zero to the two reserved mode bits.
// (R12) Firmware loads IN byte counts from zero to thirty-two.
// (R13) OUT/SETUP count becomes received bytes plus two for CRC.
// (R14) Data-valid set when buffer data arrives with good CRC.
// (R15) Bad CRC still interrupts but clears data-valid.
// (R16) Count bit 7 chooses DATA0 or DATA1 for IN.
// (R17) OUT/SETUP copy the received toggle into count bit 7.
// (R18) Endpoint 0 count refuses CPU writes after update until read.
// (R19) Only a read after the update point unlocks endpoint 0.
// (R20) SETUP flag held high until control data phase ends.
// (R21) Update point refreshes mode and count, then locks endpoint 0.
// (R22) Endpoint interrupt flag set exactly at the update point.
// (R23) Five-endpoint setting turns register 0x42 into non-control layout.
// (R24) Check answer ACKs only zero-length OUT with toggle one.
// (R25) Ignore sends no handshake whatever.
// (R26) Interrupt on valid completion or on corrupted OUT/SETUP buffer.
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module uem_core #(
  parameter int NUM_EP = 5,
  parameter int BIG_EP_BYTES = 32,
  parameter int SMALL_EP_BYTES = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output wire logic wb_ack_o,
  output wire logic [31:0] wb_dat_o,
  // Token and data strobes from the serial interface engine
  input wire logic tok_stb,
  input wire uem_pkg::uem_pid_t tok_pid,
  input wire logic [2:0] tok_ep,
  input wire logic rx_start_stb,
  input wire logic rx_end_stb,
  input wire logic [5:0] rx_cnt,
  input wire logic rx_crc_ok,
  input wire logic rx_tog,
  input wire logic in_end_stb,
  input wire logic in_acked,
  // Answers to the serial interface engine
  output wire logic resp_stb,
  output wire uem_pkg::uem_resp_t resp_code,
  output wire logic [5:0] tx_cnt,
  output wire logic tx_tog,
  output wire logic [4:0] ep_irq
);
  import uem_pkg::*;

  // Elaboration checks on the parameters
  if (NUM_EP != 5) begin : g_ep_chk
    $error("uem_core serves exactly five endpoints");
  end
  if (BIG_EP_BYTES > 32 || SMALL_EP_BYTES > BIG_EP_BYTES) begin : g_sz_chk
    $error("uem_core endpoint sizes out of range");
  end

  localparam logic [5:0] BIG_LIM = 6'(BIG_EP_BYTES + 2);
  localparam logic [5:0] SMALL_LIM = 6'(SMALL_EP_BYTES + 2);

  uem_state_t state_ff, nxt_state;
  logic [7:0] mode_ff [NUM_EP];
  logic [7:0] cnt_ff [NUM_EP];
  logic [NUM_EP-1:0] lock_ff;
  logic [NUM_EP-1:0] hold_ff;
  logic [7:0] cfg_ff;
  logic [2:0] txn_ep_ff;
  uem_pid_t txn_pid_ff;
  uem_resp_t txn_rsp_ff;
  logic resp_stb_ff;
  uem_resp_t resp_code_ff;
  logic [5:0] tx_cnt_ff;
  logic tx_tog_ff;
  logic [4:0] ep_irq_ff;
  logic wb_ack_ff;
  logic [31:0] wb_dat_ff;

  // Control endpoint test: endpoint 0, and 0x42 unless five endpoints
  function automatic logic uem_is_ctrl(input logic [2:0] ep,
                                       input logic five);
    return (ep == 3'h0) || (ep == 3'h3 && !five); // see R23
  endfunction : uem_is_ctrl

  // Answer chosen by mode, stall bit and token kind
  function automatic uem_resp_t uem_decode(input logic [3:0] m,
                                           input logic stall,
                                           input uem_pid_t pid);
    uem_resp_t r;
    r = RSP_IGNORE;
    case (pid)
      PID_SETUP: begin // see R03
        case (m)
          MD_NAK_INOUT, MD_STATUS_OUT, MD_STALL_INOUT, MD_IGNORE_INOUT,
          MD_STATUS_IN, MD_NAK_OUT_STIN, MD_ACK_OUT_STIN,
          MD_NAK_IN_STOUT, MD_ACK_IN_STOUT: r = RSP_ACK; // see R02
          default: r = RSP_IGNORE; // see R01
        endcase
      end
      PID_IN: begin
        case (m)
          MD_NAK_INOUT, MD_NAK_IN, MD_NAK_IN_STOUT: r = RSP_NAK; // see R06
          MD_STATUS_OUT, MD_STALL_INOUT: r = RSP_STALL; // see R03
          MD_STATUS_IN, MD_NAK_OUT_STIN,
          MD_ACK_OUT_STIN: r = RSP_TX0; // see R05
          MD_ISO_IN, MD_ACK_IN_STOUT: r = RSP_TXCNT; // see R07
          MD_ACK_IN: r = stall ? RSP_STALL : RSP_TXCNT; // see R06
          MD_ACK_OUT: r = stall ? RSP_STALL : RSP_IGNORE; // see R08
          default: r = RSP_IGNORE;
        endcase
      end
      PID_OUT: begin
        case (m)
          MD_NAK_INOUT, MD_NAK_OUT, MD_NAK_OUT_STIN: r = RSP_NAK; // see R04
          MD_STATUS_OUT, MD_NAK_IN_STOUT,
          MD_ACK_IN_STOUT: r = RSP_CHECK; // see R07
          MD_STALL_INOUT, MD_STATUS_IN: r = RSP_STALL; // see R03
          MD_ISO_OUT: r = RSP_ALWAYS; // see R03
          MD_ACK_OUT: r = stall ? RSP_STALL : RSP_ACK; // see R04
          MD_ACK_OUT_STIN: r = RSP_ACK; // see R05
          MD_ACK_IN: r = stall ? RSP_STALL : RSP_IGNORE; // see R08
          default: r = RSP_IGNORE;
        endcase
      end
      default: r = RSP_IGNORE;
    endcase
    return r;
  endfunction : uem_decode

  // ACK modes fall back to their NAK forms after a handshake
  function automatic logic [3:0] uem_after_ack(input logic [3:0] m);
    case (m)
      MD_ACK_OUT: return MD_NAK_OUT; // see R04
      MD_ACK_OUT_STIN: return MD_NAK_OUT_STIN; // see R05
      MD_ACK_IN: return MD_NAK_IN; // see R06
      MD_ACK_IN_STOUT: return MD_NAK_IN_STOUT; // see R07
      default: return m;
    endcase
  endfunction : uem_after_ack

  // Register index to {hit, is_mode, endpoint}
  function automatic logic [4:0] uem_map(input logic [6:0] idx);
    case (idx)
      IDX_CNT0: return 5'h10;
      IDX_MODE0: return 5'h18;
      IDX_CNT1: return 5'h11;
      IDX_MODE1: return 5'h19;
      IDX_CNT2: return 5'h12;
      IDX_MODE2: return 5'h1A;
      IDX_CNT3: return 5'h13;
      IDX_MODE3: return 5'h1B;
      IDX_CNT4: return 5'h14;
      IDX_MODE4: return 5'h1C;
      default: return 5'h00;
    endcase
  endfunction : uem_map

  // Token-time and data-end decisions
  logic five_ep;
  logic tok_ep_ok;
  logic [7:0] tok_mode;
  logic tok_ctrl;
  uem_resp_t tok_rsp;
  logic [7:0] upd_mode;
  logic [7:0] upd_cnt;
  logic upd_ctrl;
  logic rx_good;
  logic wr_buf;
  logic end_ack;
  uem_resp_t end_rsp;
  logic upd;
  logic upd_ack;
  logic setup_pt;

  always_comb begin
    five_ep = cfg_ff[CFG_FIVE_EP_BIT];
    tok_ep_ok = tok_ep < 3'(NUM_EP);
    tok_mode = tok_ep_ok ? mode_ff[tok_ep] : REG_RST;
    tok_ctrl = uem_is_ctrl(tok_ep, five_ep);
    tok_rsp = uem_decode(tok_mode[3:0],
                         !tok_ctrl && tok_mode[MODE_STALL_BIT], tok_pid);
    upd_mode = mode_ff[txn_ep_ff];
    upd_cnt = cnt_ff[txn_ep_ff];
    upd_ctrl = uem_is_ctrl(txn_ep_ff, five_ep);
    rx_good = rx_crc_ok && rx_cnt <= ((txn_ep_ff == 3'h1 ||
              txn_ep_ff == 3'h2) && cfg_ff[CFG_BIG_EP_BIT] ?
              BIG_LIM : SMALL_LIM);
    end_ack = 1'b0;
    end_rsp = RSP_IGNORE; // see R25
    case (txn_rsp_ff)
      RSP_ACK: end_ack = rx_good;
      RSP_CHECK: end_ack = rx_good && rx_cnt == CRC_BYTES && rx_tog; // see R24
      default: end_ack = 1'b0;
    endcase
    if (rx_good) begin
      case (txn_rsp_ff)
        RSP_ACK, RSP_CHECK: end_rsp = end_ack ? RSP_ACK : RSP_STALL;
        RSP_NAK: end_rsp = RSP_NAK;
        RSP_STALL: end_rsp = RSP_STALL;
        default: end_rsp = RSP_IGNORE;
      endcase
    end
    wr_buf = txn_rsp_ff == RSP_ACK || txn_rsp_ff == RSP_CHECK ||
             txn_rsp_ff == RSP_ALWAYS;
    upd = (state_ff == ST_DATA && rx_end_stb && wr_buf) ||
          (state_ff == ST_INWAIT && in_end_stb && in_acked);
    upd_ack = (state_ff == ST_DATA && end_ack) ||
              (state_ff == ST_INWAIT && in_acked);
    setup_pt = state_ff == ST_DATA && rx_start_stb &&
               txn_pid_ff == PID_SETUP && upd_ctrl; // see R20
  end

  // Next transaction state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (tok_stb && tok_ep_ok && tok_rsp != RSP_IGNORE) begin
          if (tok_pid == PID_IN) begin
            nxt_state = (tok_rsp == RSP_TXCNT || tok_rsp == RSP_TX0) ?
                        ST_INWAIT : ST_IDLE;
          end else begin
            nxt_state = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (rx_end_stb) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_INWAIT: begin
        if (in_end_stb || tok_stb) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Transaction tracker and latched token
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      txn_ep_ff <= 3'h0;
      txn_pid_ff <= PID_SETUP;
      txn_rsp_ff <= RSP_IGNORE;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE && tok_stb && tok_ep_ok) begin
        txn_ep_ff <= tok_ep;
        txn_pid_ff <= tok_pid;
        txn_rsp_ff <= tok_rsp;
      end
    end
  end

  // Handshake and IN data answers to the engine
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      resp_stb_ff <= 1'b0;
      resp_code_ff <= RSP_IGNORE;
      tx_cnt_ff <= 6'h00;
      tx_tog_ff <= 1'b0;
    end else begin
      resp_stb_ff <= 1'b0;
      if (state_ff == ST_IDLE && tok_stb && tok_ep_ok &&
          tok_pid == PID_IN && tok_rsp != RSP_IGNORE) begin
        resp_stb_ff <= 1'b1;
        resp_code_ff <= tok_rsp;
        tx_cnt_ff <= tok_rsp == RSP_TX0 ? 6'h00 : cnt_ff[tok_ep][5:0];
        tx_tog_ff <= cnt_ff[tok_ep][CNT_TOG_BIT]; // see R16
      end else if (state_ff == ST_DATA && rx_end_stb &&
                   end_rsp != RSP_IGNORE) begin
        resp_stb_ff <= 1'b1;
        resp_code_ff <= end_rsp;
      end
    end
  end

  // Endpoint interrupt pulse at the update point
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ep_irq_ff <= 5'h00;
    end else begin
      ep_irq_ff <= 5'h00;
      if (upd) begin
        ep_irq_ff[txn_ep_ff] <= 1'b1; // see R22 R26 R15
      end
    end
  end

  // Wishbone decode
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [4:0] bus_map;
  logic [7:0] rd_val;

  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !wb_ack_ff;
    bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    bus_rd = bus_req && !wb_we_i;
    bus_map = uem_map(wb_adr_i[8:2]);
    rd_val = REG_RST;
    if (wb_adr_i[8:2] == IDX_CFG) begin
      rd_val = cfg_ff;
    end else if (bus_map[4]) begin
      rd_val = bus_map[3] ? mode_ff[bus_map[2:0]] : cnt_ff[bus_map[2:0]];
    end
  end

  // Bus acknowledge and read data, one wait state
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
    end else begin
      wb_ack_ff <= bus_req;
      if (bus_rd) begin
        wb_dat_ff <= {24'h00_0000, rd_val};
      end
    end
  end

  // Configuration register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg_ff <= REG_RST;
    end else if (bus_wr && wb_adr_i[8:2] == IDX_CFG) begin
      cfg_ff <= wb_dat_i[7:0];
    end
  end

  // Mode, count, lock and SETUP hold of each endpoint
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_EP; i++) begin
        mode_ff[i] <= REG_RST;
        cnt_ff[i] <= REG_RST;
      end
      lock_ff <= '0;
      hold_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (upd && txn_ep_ff == 3'(i)) begin
          if (txn_pid_ff != PID_IN) begin
            cnt_ff[i] <= {rx_tog, rx_good, rx_cnt}; // see R13 R14 R17 R21
          end
          if (upd_ack) begin
            mode_ff[i][MODE_ACK_BIT] <= 1'b1; // see R10
            if (txn_pid_ff == PID_SETUP && upd_ctrl &&
                upd_mode[3:0] != MD_DISABLE) begin
              mode_ff[i][3:0] <= MD_NAK_INOUT; // see R02
            end else begin
              mode_ff[i][3:0] <= uem_after_ack(upd_mode[3:0]); // see R21
            end
          end
          if (upd_ctrl) begin
            lock_ff[i] <= 1'b1; // see R21 R18
            if (txn_pid_ff == PID_IN) begin
              mode_ff[i][MODE_IN_BIT] <= 1'b1;
              hold_ff[i] <= 1'b0;
            end else if (txn_pid_ff == PID_OUT) begin
              mode_ff[i][MODE_OUT_BIT] <= 1'b1;
              hold_ff[i] <= 1'b0; // see R20
            end
          end
        end else begin
          if (bus_rd && bus_map[4] && bus_map[2:0] == 3'(i)) begin
            lock_ff[i] <= 1'b0; // see R19
          end
          if (bus_wr && bus_map[4] && bus_map[2:0] == 3'(i)) begin
            if (!bus_map[3]) begin
              if (!(lock_ff[i] && uem_is_ctrl(3'(i), five_ep))) begin
                cnt_ff[i] <= wb_dat_i[7:0]; // see R18
              end
            end else if (uem_is_ctrl(3'(i), five_ep)) begin
              mode_ff[i][MODE_SETUP_BIT] <= hold_ff[i]; // see R20
              if (!lock_ff[i]) begin
                mode_ff[i][6:0] <= wb_dat_i[6:0];
              end
            end else begin
              mode_ff[i] <= wb_dat_i[7:0]; // see R23
            end
          end
          if (setup_pt && txn_ep_ff == 3'(i)) begin
            mode_ff[i][MODE_SETUP_BIT] <= 1'b1; // see R20
            hold_ff[i] <= 1'b1;
          end
        end
      end
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign resp_stb = resp_stb_ff;
  assign resp_code = resp_code_ff;
  assign tx_cnt = tx_cnt_ff;
  assign tx_tog = tx_tog_ff;
  assign ep_irq = ep_irq_ff;

  // Checks on the block's own behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_idle_tok;
    state_ff == ST_IDLE && tok_stb && tok_ep_ok;
  endsequence
  sequence s_data_end;
    state_ff == ST_DATA && rx_end_stb;
  endsequence

  dis_ignore_a: assert property (s_idle_tok ##0 // see R01
    tok_mode[3:0] == MD_DISABLE |=> !resp_stb_ff && state_ff == ST_IDLE)
    else $error("disabled endpoint answered");
  stall_in_a: assert property (s_idle_tok ##0 tok_pid == PID_IN && // see R08
    !tok_ctrl && tok_mode == {1'b1, 3'h0, MD_ACK_OUT}
    |=> resp_stb_ff && resp_code_ff == RSP_STALL)
    else $error("stalled IN not answered with stall");
  setup_force_a: assert property (upd && upd_ack && upd_ctrl && // see R02
    txn_pid_ff == PID_SETUP && upd_mode[3:0] != MD_DISABLE
    |=> upd_mode[3:0] == MD_NAK_INOUT)
    else $error("SETUP did not force NAK mode");
  ackout_nak_a: assert property (upd && upd_ack && // see R04
    upd_mode[3:0] == MD_ACK_OUT |=> upd_mode[3:0] == MD_NAK_OUT
    && upd_mode[MODE_ACK_BIT])
    else $error("ACK-OUT mode did not fall back");
  dval_crc_a: assert property (s_data_end ##0 wr_buf // see R14
    |=> upd_cnt[CNT_DVAL_BIT] == $past(rx_good) &&
    upd_cnt[5:0] == $past(rx_cnt) && ep_irq_ff != 5'h00)
    else $error("count or data-valid not refreshed");
  check_ack_a: assert property (s_data_end ##0 // see R24
    txn_rsp_ff == RSP_CHECK && rx_good && rx_cnt == CRC_BYTES && rx_tog
    |=> resp_stb_ff && resp_code_ff == RSP_ACK)
    else $error("status OUT not acknowledged");
  cnt_lock_a: assert property (bus_wr && bus_map == 5'h10 && // see R18
    lock_ff[0] && !(upd && txn_ep_ff == 3'h0) |=> $stable(cnt_ff[0]))
    else $error("locked count was written");
  setup_hold_a: assert property (hold_ff[0] |-> // see R20
    mode_ff[0][MODE_SETUP_BIT])
    else $error("SETUP flag dropped while held");
  irq_update_a: assert property (ep_irq_ff != 5'h00 |-> $past(upd)) // see R22
    else $error("interrupt outside the update point");
endmodule : uem_core

// ---- logic/uem_pkg.sv ----
// Package for the endpoint mode and byte-count register block.
// Assumes a 32-bit classic Wishbone master and one 100 MHz clock.
package uem_pkg;
  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_CNT0 = 7'h11;
  localparam logic [6:0] IDX_MODE0 = 7'h12;
  localparam logic [6:0] IDX_CNT1 = 7'h13;
  localparam logic [6:0] IDX_MODE1 = 7'h14;
  localparam logic [6:0] IDX_CNT2 = 7'h15;
  localparam logic [6:0] IDX_MODE2 = 7'h16;
  localparam logic [6:0] IDX_CNT3 = 7'h41;
  localparam logic [6:0] IDX_MODE3 = 7'h42;
  localparam logic [6:0] IDX_CNT4 = 7'h43;
  localparam logic [6:0] IDX_MODE4 = 7'h44;
  localparam logic [6:0] IDX_CFG = 7'h50;
  // Field positions
  localparam int MODE_STALL_BIT = 7;
  localparam int MODE_SETUP_BIT = 7;
  localparam int MODE_IN_BIT = 6;
  localparam int MODE_OUT_BIT = 5;
  localparam int MODE_ACK_BIT = 4;
  localparam int CNT_TOG_BIT = 7;
  localparam int CNT_DVAL_BIT = 6;
  localparam int CFG_FIVE_EP_BIT = 6;
  localparam int CFG_BIG_EP_BIT = 7;
  // Reset value and count figures
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [5:0] CRC_BYTES = 6'h02;
  // Endpoint mode codes
  localparam logic [3:0] MD_DISABLE = 4'h0;
  localparam logic [3:0] MD_NAK_INOUT = 4'h1;
  localparam logic [3:0] MD_STATUS_OUT = 4'h2;
  localparam logic [3:0] MD_STALL_INOUT = 4'h3;
  localparam logic [3:0] MD_IGNORE_INOUT = 4'h4;
  localparam logic [3:0] MD_ISO_OUT = 4'h5;
  localparam logic [3:0] MD_STATUS_IN = 4'h6;
  localparam logic [3:0] MD_ISO_IN = 4'h7;
  localparam logic [3:0] MD_NAK_OUT = 4'h8;
  localparam logic [3:0] MD_ACK_OUT = 4'h9;
  localparam logic [3:0] MD_NAK_OUT_STIN = 4'hA;
  localparam logic [3:0] MD_ACK_OUT_STIN = 4'hB;
  localparam logic [3:0] MD_NAK_IN = 4'hC;
  localparam logic [3:0] MD_ACK_IN = 4'hD;
  localparam logic [3:0] MD_NAK_IN_STOUT = 4'hE;
  localparam logic [3:0] MD_ACK_IN_STOUT = 4'hF;
  // Token kinds from the serial interface engine
  typedef enum logic [1:0] {
    PID_SETUP = 2'h0,
    PID_IN = 2'h1,
    PID_OUT = 2'h2
  } uem_pid_t;
  // Answers handed back to the serial interface engine
  typedef enum logic [2:0] {
    RSP_IGNORE = 3'h0,
    RSP_ACK = 3'h1,
    RSP_NAK = 3'h2,
    RSP_STALL = 3'h3,
    RSP_TXCNT = 3'h4,
    RSP_TX0 = 3'h5,
    RSP_CHECK = 3'h6,
    RSP_ALWAYS = 3'h7
  } uem_resp_t;
  // Transaction tracker states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DATA = 3'b010,
    ST_INWAIT = 3'b100
  } uem_state_t;
endpackage : uem_pkg

// ---- tb/testbench.sv ----
// Self-checking bench for the endpoint mode and count block.
// Assumes the host model file and the block package are compiled first.
`timescale 1ns/1ps
module testbench;
  import uem_pkg::*;
  logic sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [8:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic tok_stb, rx_start_stb, rx_end_stb, rx_crc_ok, rx_tog;
  logic in_end_stb, in_acked, resp_stb, tx_tog;
  logic [2:0] tok_ep;
  logic [5:0] rx_cnt, tx_cnt;
  logic [4:0] ep_irq;
  uem_pid_t tok_pid;
  uem_resp_t resp_code;
  int error_cnt = 0;
  int checks = 0;
  logic [31:0] seed = 32'h131F9193;
  logic [6:0] idx [10] = '{IDX_CNT0, IDX_MODE0, IDX_CNT1, IDX_MODE1,
    IDX_CNT2, IDX_MODE2, IDX_CNT3, IDX_MODE3, IDX_CNT4, IDX_MODE4};
  // Block and host model
  uem_core uem_core_i (.sys_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .tok_stb,
    .tok_pid, .tok_ep, .rx_start_stb, .rx_end_stb, .rx_cnt, .rx_crc_ok,
    .rx_tog, .in_end_stb, .in_acked, .resp_stb, .resp_code, .tx_cnt,
    .tx_tog, .ep_irq);
  uem_host_model host_i (.sys_clk, .tok_stb, .tok_pid, .tok_ep,
    .rx_start_stb, .rx_end_stb, .rx_cnt, .rx_crc_ok, .rx_tog, .in_end_stb,
    .in_acked, .resp_stb, .resp_code, .tx_cnt, .tx_tog, .ep_irq);
  // 100 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Repeatable xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Expected answers to IN and to zero-length DATA1 OUT by mode
  function automatic logic [2:0] exp_in(input logic [3:0] m, input logic s);
    logic [2:0] t [16] = '{0, 2, 3, 3, 0, 0, 5, 4, 0, 0, 5, 5, 2, 4, 2, 4};
    return (s && (m == MD_ACK_IN || m == MD_ACK_OUT)) ? RSP_STALL : t[m];
  endfunction : exp_in
  function automatic logic [2:0] exp_out(input logic [3:0] m, input logic s);
    logic [2:0] t [16] = '{0, 2, 1, 3, 0, 0, 3, 0, 2, 1, 2, 1, 0, 0, 1, 1};
    if (s && (m == MD_ACK_OUT || m == MD_ACK_IN)) return RSP_STALL;
    return t[m];
  endfunction : exp_out
  // ACK modes fall back to their NAK forms
  function automatic logic [3:0] nxt_mode(input logic [3:0] m);
    return (m inside {4'h9, 4'hB, 4'hD, 4'hF}) ? m - 4'h1 : m;
  endfunction : nxt_mode
  // Verdict and end of run
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Classic Wishbone single cycle, ack awaited under a bound
  task automatic wb(input logic w, input logic [6:0] a, input logic [7:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= {a, 2'h0};
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (wb_ack_o !== 1'h1) begin
      error_cnt++;
      test_done();
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'h1, a, d, q);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'h0, a, 8'h00, q);
    check(q, {24'h000000, e});
  endtask : rd
  // Main sequence
  initial begin
    logic [31:0] v;
    logic [2:0] r;
    logic [4:0] i;
    logic [6:0] tx;
    logic [5:0] c;
    logic [3:0] md;
    logic s, a, ack;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 44'h0;
    wb_sel_i = 4'h1;
    srst = 1'h1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    foreach (idx[n]) rd(idx[n], REG_RST);
    rd(7'h7F, 8'h00);
    // Every mode for IN and OUT, then the stall bit in ACK-IN and ACK-OUT
    for (int k = 0; k < 18; k++) begin
      md = (k < 16) ? 4'(k) : ((k == 16) ? MD_ACK_IN : MD_ACK_OUT);
      s = (k >= 16);
      v = rnd();
      c = 6'(v[15:8] % 8'h21);
      a = v[16] & (md == MD_ACK_IN) & ~s;
      wr(IDX_CNT1, {v[7], 1'h0, c});
      wr(IDX_MODE1, {s, 3'h0, md});
      host_i.in_xfer(3'h1, a, r, i, tx);
      check(r, exp_in(md, s));
      if (r == RSP_TXCNT) check(tx, {v[7], c});
      if (r == RSP_TX0) check(tx, {v[7], 6'h00});
      check(i, a ? 5'h02 : 5'h00);
      rd(IDX_MODE1, a ? {s, 3'h1, nxt_mode(md)} : {s, 3'h0, md});
      wr(IDX_MODE1, {s, 3'h0, md});
      host_i.out_xfer(PID_OUT, 3'h1, CRC_BYTES, 1'h1, 1'h1, r, i);
      check(r, exp_out(md, s));
      ack = (exp_out(md, s) == RSP_ACK);
      check(i, (ack || md == MD_ISO_OUT) ? 5'h02 : 5'h00);
      rd(IDX_MODE1, ack ? {s, 3'h1, nxt_mode(md)} : {s, 3'h0, md});
      if (ack) rd(IDX_CNT1, 8'hC2);
    end
    // Check answer refuses an OUT that is not zero length
    wr(IDX_MODE1, {4'h0, MD_STATUS_OUT});
    host_i.out_xfer(PID_OUT, 3'h1, 6'h04, 1'h1, 1'h1, r, i);
    check(r, RSP_STALL);
    // Endpoint 0 SETUP, locks and unlock by read
    wr(IDX_MODE0, {4'h0, MD_STALL_INOUT});
    host_i.out_xfer(PID_SETUP, 3'h0, 6'h0A, 1'h1, 1'h0, r, i);
    check(r, RSP_ACK);
    check(i, 5'h01);
    wr(IDX_CNT0, 8'h05);
    wr(IDX_MODE0, 8'h02);
    rd(IDX_MODE0, 8'h91);
    rd(IDX_CNT0, 8'h4A);
    wr(IDX_CNT0, 8'h05);
    rd(IDX_CNT0, 8'h05);
    host_i.out_xfer(PID_SETUP, 3'h0, 6'h0A, 1'h0, 1'h1, r, i);
    check(r, RSP_IGNORE);
    check(i, 5'h01);
    rd(IDX_CNT0, 8'h8A);
    // Register 0x42 as control, then in five-endpoint layout
    for (int k = 0; k < 2; k++) begin
      wr(IDX_CFG, k ? 8'h40 : 8'h00);
      wr(IDX_MODE3, {1'h1, 3'h0, MD_ACK_IN});
      host_i.in_xfer(3'h3, 1'h0, r, i, tx);
      check(r, k ? RSP_STALL : RSP_TXCNT);
    end
    test_done();
  end
endmodule : testbench

// ---- tb/uem_host_model.sv ----
// Host-side engine model: token, data and handshake strobes.
// Assumes the bench calls its tasks and shares sys_clk.
`timescale 1ns/1ps
module uem_host_model (
  // Clock
  input wire logic sys_clk,
  // Strobes to the block
  output logic tok_stb,
  output uem_pkg::uem_pid_t tok_pid,
  output logic [2:0] tok_ep,
  output logic rx_start_stb,
  output logic rx_end_stb,
  output logic [5:0] rx_cnt,
  output logic rx_crc_ok,
  output logic rx_tog,
  output logic in_end_stb,
  output logic in_acked,
  // Answers from the block
  input wire logic resp_stb,
  input wire uem_pkg::uem_resp_t resp_code,
  input wire logic [5:0] tx_cnt,
  input wire logic tx_tog,
  input wire logic [4:0] ep_irq
);
  import uem_pkg::*;
  // Idle levels
  initial begin
    {tok_stb, rx_start_stb, rx_end_stb, in_end_stb, in_acked} = 5'h00;
    tok_pid = PID_IN;
    {tok_ep, rx_cnt, rx_crc_ok, rx_tog} = 11'h000;
  end
  // Gather answer code and interrupts over three edges
  task automatic watch(output logic [2:0] r, output logic [4:0] q);
    r = 3'h0;
    q = 5'h00;
    repeat (3) begin
      @(posedge sys_clk);
      if (resp_stb === 1'h1) r = resp_code;
      q = q | ep_irq;
    end
  endtask : watch
  // One token pulse; endpoint lines scrambled once released
  task automatic token(input uem_pid_t p, input logic [2:0] e);
    @(posedge sys_clk);
    tok_stb <= 1'h1;
    tok_pid <= p;
    tok_ep <= e;
    @(posedge sys_clk);
    tok_stb <= 1'h0;
    tok_ep <= ~e;
  endtask : token
  // SETUP or OUT token followed by its data packet
  task automatic out_xfer(input uem_pid_t p, input logic [2:0] e,
      input logic [5:0] c, input logic ok, input logic t,
      output logic [2:0] r, output logic [4:0] q);
    token(p, e);
    @(posedge sys_clk);
    rx_start_stb <= 1'h1;
    @(posedge sys_clk);
    rx_start_stb <= 1'h0;
    rx_end_stb <= 1'h1;
    {rx_cnt, rx_crc_ok, rx_tog} <= {c, ok, t};
    @(posedge sys_clk);
    rx_end_stb <= 1'h0;
    {rx_cnt, rx_crc_ok, rx_tog} <= ~{c, ok, t};
    watch(r, q);
  endtask : out_xfer
  // IN token; host handshake only after a data answer
  task automatic in_xfer(input logic [2:0] e, input logic a,
      output logic [2:0] r, output logic [4:0] q, output logic [6:0] tx);
    logic [2:0] d;
    token(PID_IN, e);
    watch(r, q);
    tx = {tx_tog, tx_cnt};
    if (r == RSP_TXCNT || r == RSP_TX0) begin
      @(posedge sys_clk);
      in_end_stb <= 1'h1;
      in_acked <= a;
      @(posedge sys_clk);
      in_end_stb <= 1'h0;
      in_acked <= ~a;
      watch(d, q);
    end
  endtask : in_xfer
endmodule : uem_host_model
